//--- hdl/fasl_pkg.sv
package fasl_pkg;

    // Status source indices, shared by the status latch and both alert outputs
    localparam int NSRC = 13;
    localparam int SRC_UV = 0;
    localparam int SRC_OV = 1;
    localparam int SRC_OC = 2;
    localparam int SRC_CML = 3;
    localparam int SRC_REGULATION_TIMER_ACTIVE_WARNING = 4;
    localparam int SRC_IOUT_OC = 5;
    localparam int SRC_IOUT_W2 = 6;
    localparam int SRC_VIN_UV = 7;
    localparam int SRC_VIN_OV = 8;
    localparam int SRC_VAUX_UV = 9;
    localparam int SRC_VAUX_OV = 10;
    localparam int SRC_PIN_OP = 11;
    localparam int SRC_FET_BAD = 12;
    localparam int NCMP = 7;

    // Alert source-enable word layout
    localparam int CFG_SRC_W = 12;
    localparam int CFG_INV_BIT = 13;
    localparam int CFG_CMP_BIT = 14;
    localparam int CFG_FET_BIT = 15;
    localparam logic [15:0] ALERT1_RST = 16'h8000;
    localparam logic [15:0] ALERT2_RST = 16'h0000;

    // Command codes
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_IOUT_OC_LIM = 8'h4a;
    localparam logic [7:0] CMD_VIN_OV_LIM = 8'h57;
    localparam logic [7:0] CMD_VIN_UV_LIM = 8'h58;
    localparam logic [7:0] CMD_PIN_OP_LIM = 8'h6b;
    localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
    localparam logic [7:0] CMD_MFR_STATUS = 8'h80;
    localparam logic [7:0] CMD_VIN = 8'h88;
    localparam logic [7:0] CMD_IOUT = 8'h8c;
    localparam logic [7:0] CMD_PEAK_IOUT = 8'hd0;
    localparam logic [7:0] CMD_PEAK_VIN = 8'hd1;
    localparam logic [7:0] CMD_PEAK_VAUX = 8'hd2;
    localparam logic [7:0] CMD_ALERT1_CFG = 8'hd5;
    localparam logic [7:0] CMD_ALERT2_CFG = 8'hd6;
    localparam logic [7:0] CMD_IOUT_W2_LIM = 8'hd7;
    localparam logic [7:0] CMD_VAUX = 8'hdd;
    localparam logic [7:0] CMD_VAUX_OV_LIM = 8'hde;
    localparam logic [7:0] CMD_VAUX_UV_LIM = 8'hdf;

    localparam int OP_ON_BIT = 7;
    localparam logic [15:0] LIM_MAX12 = 16'h0fff;
    localparam logic [15:0] LIM_MIN = 16'h0000;
    localparam logic [15:0] LIM_PIN_RST = 16'h7fff;

    // Shutdown cause field in the manufacturer status byte, bits [1:0]
    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_UV = 2'h1;
    localparam logic [1:0] CAUSE_OV = 2'h2;
    localparam logic [1:0] CAUSE_OC = 2'h3;

    // Code formats: current is offset binary around mid-scale
    localparam logic [11:0] IOUT_ZERO_CODE = 12'h800;
    localparam int LSB_25MV_NV = 12400;
    localparam int LSB_50MV_NV = 24770;
    localparam int LSB_VIN_NV = 368000;

    // Alert response address and its read-direction address byte
    localparam logic [6:0] ARA_ADDR = 7'h0c;
    localparam logic [7:0] ARA_RD_BYTE = {ARA_ADDR, 1'b1};
    localparam logic [7:0] PEC_POLY = 8'h07;

    typedef enum logic [1:0] {
        ARA_IDLE = 2'b01,
        ARA_SEND = 2'b10
    } fasl_ara_e;

endpackage

//--- hdl/fasl_stat_if.sv
`timescale 1ns/1ps
`default_nettype none

interface fasl_stat_if #(parameter int N = 13);
    logic [N-1:0] cond;
    logic [N-1:0] stat;
    logic [N-1:0] rise;
    logic [N-1:0] live;
    logic clr;
    logic rel_all;

    modport ctrl(output cond, output live, output clr, output rel_all, input stat);
    modport latch(input cond, input clr, output stat, output rise);
    modport pin(input rise, input live, input clr, input rel_all);
endinterface

`default_nettype wire

//--- hdl/fasl_latch.sv
`timescale 1ns/1ps
`default_nettype none

module fasl_latch
    import fasl_pkg::*;
#(
    parameter int N = NSRC
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    fasl_stat_if.latch s
);
    typedef struct packed {
        logic [N-1:0] stat;
    } fasl_latch_s;

    fasl_latch_s st_r;
    fasl_latch_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        // A condition present during a clear keeps its bit set
        st_nxt.stat = s.cond | (st_r.stat & ~{N{s.clr}});
        s.rise = st_nxt.stat & ~st_r.stat;
    end

    assign s.stat = st_r.stat;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

`default_nettype wire

//--- hdl/fasl_alert_pin.sv
`timescale 1ns/1ps
`default_nettype none

module fasl_alert_pin
    import fasl_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    fasl_stat_if.pin s,
    input wire logic [15:0] cfg_i,
    output logic active_o,
    output logic pin_o,
    output logic pin_oe_o
);
    typedef struct packed {
        logic flag;
        logic act;
        logic oe;
        logic pin;
    } fasl_pin_s;

    fasl_pin_s st_r;
    fasl_pin_s st_nxt;
    logic [NSRC-1:0] en;

    assign en = {cfg_i[CFG_FET_BIT], cfg_i[CFG_SRC_W-1:0]};

    always_comb begin
        st_nxt = st_r;
        // Both outputs share the clear and the release, so their latched flags drop together
        if (s.clr || s.rel_all) begin
            st_nxt.flag = 1'b0;
        end
        // Only a fresh 0-to-1 of an enabled bit raises; it beats a same-cycle clear
        if (|(s.rise & en)) begin
            st_nxt.flag = 1'b1;
        end
        if (cfg_i[CFG_CMP_BIT]) begin
            st_nxt.act = |(s.live & en);
        end else begin
            st_nxt.act = st_nxt.flag;
        end
        // Open drain pulls low when active, or when idle if inverted
        st_nxt.oe = st_nxt.act ^ cfg_i[CFG_INV_BIT];
    end

    assign active_o = st_r.act;
    assign pin_oe_o = st_r.oe;
    // Open drain data side never leaves its reset value of 0
    assign pin_o = st_r.pin;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

`default_nettype wire

//--- hdl/fasl_top.sv
`timescale 1ns/1ps
`default_nettype none

module fasl_top
    import fasl_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h10
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic uv_fault_i,
    input wire logic ov_fault_i,
    input wire logic oc_timeout_i,
    input wire logic regulation_timer_active_warning_i,
    input wire logic fet_bad_i,
    input wire logic cml_err_i,
    input wire logic sample_valid_i,
    input wire logic [11:0] vin_code_i,
    input wire logic [11:0] vaux_code_i,
    input wire logic [11:0] iout_code_i,
    input wire logic [15:0] pin_val_i,
    input wire logic cmd_wr_i,
    input wire logic cmd_rd_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [15:0] cmd_wdata_i,
    output logic [15:0] rd_data_o,
    output logic rd_valid_o,
    output logic rd_err_o,
    input wire logic ara_rd_i,
    input wire logic ara_lost_i,
    input wire logic ara_ack_i,
    output logic ara_resp_o,
    output logic [7:0] ara_data_o,
    output logic [7:0] ara_pec_o,
    output logic hs_enable_o,
    output logic alert1_o,
    output logic alert1_oe_o,
    output logic alert2_o,
    output logic alert2_oe_o
);
    typedef struct packed {
        logic op_on;
        logic trip;
        logic hs_en;
        logic [1:0] cause;
        logic [15:0] lim_ioc;
        logic [15:0] lim_iw2;
        logic [15:0] lim_vov;
        logic [15:0] lim_vuv;
        logic [15:0] lim_aov;
        logic [15:0] lim_auv;
        logic [15:0] lim_pop;
        logic [11:0] vin;
        logic [11:0] iout;
        logic [11:0] vaux;
        logic [11:0] pk_vin;
        logic [11:0] pk_iout;
        logic [11:0] pk_vaux;
        logic [NCMP-1:0] cmp;
        logic [15:0] a1cfg;
        logic [15:0] a2cfg;
        logic [15:0] rd_data;
        logic rd_valid;
        logic rd_err;
        fasl_ara_e ara;
        logic ara_resp;
        logic [7:0] ara_data;
        logic [7:0] ara_pec;
    } fasl_top_s;

    fasl_top_s st_r;
    fasl_top_s st_nxt;

    fasl_stat_if #(.N(NSRC)) s ();

    logic [2:0] fault_vec;
    logic [NCMP-1:0] smp_cmp;
    logic clr_cmd;
    logic bad_cmd;
    logic turn_on;
    logic a1_act;
    logic a2_act;

    function automatic logic [7:0] fasl_crc8(input logic [15:0] msg);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ msg[i]) ? PEC_POLY : 8'h00);
        end
        return c;
    endfunction

    // Fault inputs are never gated by any setting
    assign fault_vec = {oc_timeout_i, ov_fault_i, uv_fault_i};

    // Strict comparisons: equality never trips a warning
    assign smp_cmp = {
        pin_val_i > st_r.lim_pop,
        {4'h0, vaux_code_i} > st_r.lim_aov,
        {4'h0, vaux_code_i} < st_r.lim_auv,
        {4'h0, vin_code_i} > st_r.lim_vov,
        {4'h0, vin_code_i} < st_r.lim_vuv,
        {4'h0, iout_code_i} < st_r.lim_iw2,
        {4'h0, iout_code_i} > st_r.lim_ioc
    };

    always_comb begin
        st_nxt = st_r;
        st_nxt.rd_valid = 1'b0;
        st_nxt.rd_err = 1'b0;
        clr_cmd = 1'b0;
        bad_cmd = 1'b0;
        s.rel_all = 1'b0;

        if (cmd_wr_i) begin
            case (cmd_code_i)
                CMD_OPERATION: st_nxt.op_on = cmd_wdata_i[OP_ON_BIT];
                CMD_CLEAR_FAULTS: clr_cmd = 1'b1;
                CMD_IOUT_OC_LIM: st_nxt.lim_ioc = cmd_wdata_i;
                CMD_IOUT_W2_LIM: st_nxt.lim_iw2 = cmd_wdata_i;
                CMD_VIN_OV_LIM: st_nxt.lim_vov = cmd_wdata_i;
                CMD_VIN_UV_LIM: st_nxt.lim_vuv = cmd_wdata_i;
                CMD_VAUX_OV_LIM: st_nxt.lim_aov = cmd_wdata_i;
                CMD_VAUX_UV_LIM: st_nxt.lim_auv = cmd_wdata_i;
                CMD_PIN_OP_LIM: st_nxt.lim_pop = cmd_wdata_i;
                CMD_ALERT1_CFG: st_nxt.a1cfg = cmd_wdata_i;
                CMD_ALERT2_CFG: st_nxt.a2cfg = cmd_wdata_i;
                // Peaks clear only on a zero write; other values are dropped
                CMD_PEAK_VIN: begin
                    if (cmd_wdata_i == 16'h0000) begin
                        st_nxt.pk_vin = 12'h000;
                    end
                end
                CMD_PEAK_IOUT: begin
                    if (cmd_wdata_i == 16'h0000) begin
                        st_nxt.pk_iout = 12'h000;
                    end
                end
                CMD_PEAK_VAUX: begin
                    if (cmd_wdata_i == 16'h0000) begin
                        st_nxt.pk_vaux = 12'h000;
                    end
                end
                default: bad_cmd = 1'b1;
            endcase
        end

        // Off-then-on through the operation bit acts as a clear
        turn_on = ~st_r.op_on & st_nxt.op_on;
        s.clr = clr_cmd | turn_on;

        if (clr_cmd && !(|fault_vec)) begin
            st_nxt.cause = CAUSE_NONE;
        end
        if (turn_on) begin
            st_nxt.trip = 1'b0;
        end
        // Only faults reach the trip; warnings have no path here
        if (|fault_vec) begin
            if (st_r.hs_en && !st_r.trip) begin
                if (uv_fault_i) begin
                    st_nxt.cause = CAUSE_UV;
                end else if (ov_fault_i) begin
                    st_nxt.cause = CAUSE_OV;
                end else begin
                    st_nxt.cause = CAUSE_OC;
                end
            end
            st_nxt.trip = 1'b1;
        end
        st_nxt.hs_en = st_nxt.op_on & ~st_nxt.trip & ~(|fault_vec);

        // Codes are stored exactly as converted, no scaling
        if (sample_valid_i) begin
            st_nxt.vin = vin_code_i;
            st_nxt.iout = iout_code_i;
            st_nxt.vaux = vaux_code_i;
            st_nxt.cmp = smp_cmp;
            if (vin_code_i > st_nxt.pk_vin) begin
                st_nxt.pk_vin = vin_code_i;
            end
            if (iout_code_i > st_nxt.pk_iout) begin
                st_nxt.pk_iout = iout_code_i;
            end
            if (vaux_code_i > st_nxt.pk_vaux) begin
                st_nxt.pk_vaux = vaux_code_i;
            end
        end

        // Latch inputs: comparator warnings arrive once per sample, faults and the other inputs as levels
        s.cond = '0;
        s.cond[SRC_UV] = uv_fault_i;
        s.cond[SRC_OV] = ov_fault_i;
        s.cond[SRC_OC] = oc_timeout_i;
        s.cond[SRC_CML] = cml_err_i | bad_cmd;
        s.cond[SRC_REGULATION_TIMER_ACTIVE_WARNING] = regulation_timer_active_warning_i;
        s.cond[SRC_FET_BAD] = fet_bad_i;
        s.cond[SRC_IOUT_OC +: NCMP] = {NCMP{sample_valid_i}} & smp_cmp;
        s.live = '0;
        s.live[SRC_UV] = uv_fault_i;
        s.live[SRC_OV] = ov_fault_i;
        s.live[SRC_OC] = oc_timeout_i;
        s.live[SRC_CML] = cml_err_i;
        s.live[SRC_REGULATION_TIMER_ACTIVE_WARNING] = regulation_timer_active_warning_i;
        s.live[SRC_FET_BAD] = fet_bad_i;
        s.live[SRC_IOUT_OC +: NCMP] = st_r.cmp;

        if (cmd_rd_i) begin
            st_nxt.rd_valid = 1'b1;
            case (cmd_code_i)
                CMD_OPERATION: st_nxt.rd_data = {8'h00, st_r.op_on, 7'h00};
                CMD_STATUS_WORD: st_nxt.rd_data = {3'h0, s.stat};
                CMD_MFR_STATUS: st_nxt.rd_data = {8'h00, a2_act, a1_act, 4'h0, st_r.cause};
                CMD_VIN: st_nxt.rd_data = {4'h0, st_r.vin};
                CMD_IOUT: st_nxt.rd_data = {4'h0, st_r.iout};
                CMD_VAUX: st_nxt.rd_data = {4'h0, st_r.vaux};
                CMD_PEAK_VIN: st_nxt.rd_data = {4'h0, st_r.pk_vin};
                CMD_PEAK_IOUT: st_nxt.rd_data = {4'h0, st_r.pk_iout};
                CMD_PEAK_VAUX: st_nxt.rd_data = {4'h0, st_r.pk_vaux};
                CMD_IOUT_OC_LIM: st_nxt.rd_data = st_r.lim_ioc;
                CMD_IOUT_W2_LIM: st_nxt.rd_data = st_r.lim_iw2;
                CMD_VIN_OV_LIM: st_nxt.rd_data = st_r.lim_vov;
                CMD_VIN_UV_LIM: st_nxt.rd_data = st_r.lim_vuv;
                CMD_VAUX_OV_LIM: st_nxt.rd_data = st_r.lim_aov;
                CMD_VAUX_UV_LIM: st_nxt.rd_data = st_r.lim_auv;
                CMD_PIN_OP_LIM: st_nxt.rd_data = st_r.lim_pop;
                CMD_ALERT1_CFG: st_nxt.rd_data = st_r.a1cfg;
                CMD_ALERT2_CFG: st_nxt.rd_data = st_r.a2cfg;
                default: begin
                    st_nxt.rd_data = 16'h0000;
                    st_nxt.rd_err = 1'b1;
                end
            endcase
        end

        // Alert response: the bus layer handles bit arbitration and PEC framing
        unique case (st_r.ara)
            ARA_IDLE: begin
                if (ara_rd_i && (a1_act || a2_act)) begin
                    st_nxt.ara = ARA_SEND;
                    st_nxt.ara_resp = 1'b1;
                    st_nxt.ara_data = {DEV_ADDR, 1'b1};
                    st_nxt.ara_pec = fasl_crc8({ARA_RD_BYTE, DEV_ADDR, 1'b1});
                end
            end
            ARA_SEND: begin
                if (ara_lost_i) begin
                    // Loser keeps its alert asserted for the next round
                    st_nxt.ara = ARA_IDLE;
                    st_nxt.ara_resp = 1'b0;
                end else if (ara_ack_i) begin
                    st_nxt.ara = ARA_IDLE;
                    st_nxt.ara_resp = 1'b0;
                    s.rel_all = 1'b1;
                end
            end
            default: begin
                st_nxt.ara = ARA_IDLE;
                st_nxt.ara_resp = 1'b0;
            end
        endcase
    end

    fasl_latch #(.N(NSRC)) u_latch (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .s(s.latch)
    );

    fasl_alert_pin u_alert1 (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .s(s.pin),
        .cfg_i(st_r.a1cfg),
        .active_o(a1_act),
        .pin_o(alert1_o),
        .pin_oe_o(alert1_oe_o)
    );

    fasl_alert_pin u_alert2 (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .s(s.pin),
        .cfg_i(st_r.a2cfg),
        .active_o(a2_act),
        .pin_o(alert2_o),
        .pin_oe_o(alert2_oe_o)
    );

    assign rd_data_o = st_r.rd_data;
    assign rd_valid_o = st_r.rd_valid;
    assign rd_err_o = st_r.rd_err;
    assign ara_resp_o = st_r.ara_resp;
    assign ara_data_o = st_r.ara_data;
    assign ara_pec_o = st_r.ara_pec;
    assign hs_enable_o = st_r.hs_en;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
            st_r.lim_ioc <= LIM_MAX12;
            st_r.lim_vov <= LIM_MAX12;
            st_r.lim_aov <= LIM_MAX12;
            st_r.lim_pop <= LIM_PIN_RST;
            st_r.lim_vuv <= LIM_MIN;
            st_r.lim_auv <= LIM_MIN;
            st_r.lim_iw2 <= LIM_MIN;
            st_r.a1cfg <= ALERT1_RST;
            st_r.a2cfg <= ALERT2_RST;
            st_r.ara <= ARA_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

`default_nettype wire

//--- test/fasl_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module fasl_top_assertions
    import fasl_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h10
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic uv_fault_i,
    input wire logic ov_fault_i,
    input wire logic oc_timeout_i,
    input wire logic cmd_wr_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic ara_rd_i,
    input wire logic ara_lost_i,
    input wire logic ara_ack_i,
    input wire logic ara_resp_o,
    input wire logic [7:0] ara_data_o,
    input wire logic hs_enable_o,
    input wire logic alert1_o,
    input wire logic alert1_oe_o,
    input wire logic alert2_o,
    input wire logic alert2_oe_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // Open drain: the data side never drives high
    chk_pins_low: assert property (alert1_o == 1'b0 && alert2_o == 1'b0)
        else $error("alert pin data not low");
    chk_fault_off: assert property ((uv_fault_i || ov_fault_i || oc_timeout_i) |=> !hs_enable_o)
        else $error("fault did not turn hot swap off");
    chk_hs_hold: assert property (hs_enable_o && !uv_fault_i && !ov_fault_i && !oc_timeout_i
        && !(cmd_wr_i && cmd_code_i == CMD_OPERATION) |=> hs_enable_o)
        else $error("hot swap changed without fault or command");
    chk_ara_reply: assert property (ara_rd_i && !ara_resp_o && (alert1_oe_o || alert2_oe_o)
        |=> ara_resp_o && ara_data_o == {DEV_ADDR, 1'b1})
        else $error("alert response missing or wrong address");
    chk_ara_quiet: assert property (ara_rd_i && !ara_resp_o && !alert1_oe_o && !alert2_oe_o
        |=> !ara_resp_o)
        else $error("answered alert response without alert");
    chk_resp_hold: assert property (ara_resp_o && !ara_ack_i && !ara_lost_i |=> ara_resp_o)
        else $error("response dropped early");
    chk_ack_release: assert property (ara_resp_o && ara_ack_i
        |=> !ara_resp_o && !alert1_oe_o && !alert2_oe_o)
        else $error("alerts not released together on ack");
    chk_lost_keep: assert property (ara_resp_o && ara_lost_i |=> !ara_resp_o
        && (alert1_oe_o || !$past(alert1_oe_o)) && (alert2_oe_o || !$past(alert2_oe_o)))
        else $error("lost arbitration released an alert");
    chk_clear_release: assert property (cmd_wr_i && cmd_code_i == CMD_CLEAR_FAULTS
        |=> !alert1_oe_o && !alert2_oe_o)
        else $error("clear did not release alerts");
endmodule

bind fasl_top fasl_top_assertions #(.DEV_ADDR(DEV_ADDR)) u_chk (.mclk_i, .rst_n_i, .uv_fault_i,
    .ov_fault_i, .oc_timeout_i, .cmd_wr_i, .cmd_code_i, .ara_rd_i, .ara_lost_i, .ara_ack_i,
    .ara_resp_o, .ara_data_o, .hs_enable_o, .alert1_o, .alert1_oe_o, .alert2_o, .alert2_oe_o);

`default_nettype wire

//--- test/fasl_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module fasl_host_model
    import fasl_pkg::*;
(
    input wire logic mclk_i,
    input wire logic ara_resp_o,
    output logic cmd_wr_i,
    output logic cmd_rd_i,
    output logic [7:0] cmd_code_i,
    output logic [15:0] cmd_wdata_i,
    output logic ara_rd_i,
    output logic ara_lost_i,
    output logic ara_ack_i
);
    initial begin
        {cmd_wr_i, cmd_rd_i, ara_rd_i, ara_lost_i, ara_ack_i} = 5'h00;
        cmd_code_i = 8'h00;
        cmd_wdata_i = 16'h0000;
    end

    // Each request waits one edge first so a strobe is never lowered and raised in one step
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge mclk_i);
        #1;
        cmd_code_i = c;
        cmd_wdata_i = d;
        cmd_wr_i = 1'b1;
        @(posedge mclk_i);
        #1;
        cmd_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [7:0] c);
        @(posedge mclk_i);
        #1;
        cmd_code_i = c;
        cmd_rd_i = 1'b1;
        @(posedge mclk_i);
        #1;
        cmd_rd_i = 1'b0;
    endtask

    // Plain receive byte; a PEC byte would only follow the address byte
    task automatic ara(input logic lost);
        @(posedge mclk_i);
        #1;
        ara_rd_i = 1'b1;
        @(posedge mclk_i);
        #1;
        ara_rd_i = 1'b0;
        if (ara_resp_o === 1'b1) begin
            ara_ack_i = !lost;
            ara_lost_i = lost;
            @(posedge mclk_i);
            #1;
            ara_ack_i = 1'b0;
            ara_lost_i = 1'b0;
        end
    endtask
endmodule

`default_nettype wire

//--- test/fasl_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module fasl_top_tb_top
    import fasl_pkg::*;
;
    localparam logic [6:0] ADDR = 7'h2b;
    localparam logic [7:0] RC [8] = '{CMD_ALERT1_CFG, CMD_ALERT2_CFG, CMD_IOUT_OC_LIM,
        CMD_VIN_OV_LIM, CMD_VIN_UV_LIM, CMD_PIN_OP_LIM, CMD_STATUS_WORD, CMD_MFR_STATUS};
    localparam logic [15:0] RV [8] = '{16'h8000, 16'h0000, 16'h0fff, 16'h0fff, 16'h0000,
        16'h7fff, 16'h0000, 16'h0000};
    logic mclk_i = 1'b0;
    logic rst_n_i, uv_fault_i, ov_fault_i, oc_timeout_i, regulation_timer_active_warning_i, fet_bad_i, sample_valid_i;
    logic cml_err_i;
    logic [11:0] vin_code_i, vaux_code_i, iout_code_i, lim;
    logic [15:0] pin_val_i, cmd_wdata_i, rd_data_o;
    logic [7:0] cmd_code_i, ara_data_o, ara_pec_o;
    logic cmd_wr_i, cmd_rd_i, rd_valid_o, rd_err_o, ara_rd_i, ara_lost_i, ara_ack_i, ara_resp_o;
    logic hs_enable_o, alert1_o, alert1_oe_o, alert2_o, alert2_oe_o;
    logic [16:0] exp_q [$];
    int fail_count = 0;
    int n_tests = 0;
    int seed = 85;

    fasl_top #(.DEV_ADDR(ADDR)) uut (.mclk_i, .rst_n_i, .uv_fault_i, .ov_fault_i, .oc_timeout_i,
        .regulation_timer_active_warning_i, .fet_bad_i, .cml_err_i, .sample_valid_i, .vin_code_i, .vaux_code_i,
        .iout_code_i, .pin_val_i, .cmd_wr_i, .cmd_rd_i, .cmd_code_i, .cmd_wdata_i, .rd_data_o,
        .rd_valid_o, .rd_err_o, .ara_rd_i, .ara_lost_i, .ara_ack_i, .ara_resp_o, .ara_data_o,
        .ara_pec_o, .hs_enable_o, .alert1_o, .alert1_oe_o, .alert2_o, .alert2_oe_o);
    fasl_host_model host (.mclk_i, .ara_resp_o, .cmd_wr_i, .cmd_rd_i, .cmd_code_i,
        .cmd_wdata_i, .ara_rd_i, .ara_lost_i, .ara_ack_i);

    always #20 mclk_i = ~mclk_i;

    task automatic cmp_rd(input logic [16:0] e, input logic [16:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected read word: expected %h seen %h", e, g);
        end
    endtask

    task automatic cmp_pin(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report;
        // A read that never answered must not slip through as a pass
        if (exp_q.size() != 0) begin
            fail_count++;
            $display("unexpected read count: expected 0 pending seen %0d", exp_q.size());
        end
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    task automatic rd(input logic [7:0] c, input logic [16:0] e);
        exp_q.push_back(e);
        host.rd(c);
    endtask

    task automatic sample(input logic [11:0] c);
        iout_code_i = c;
        vin_code_i = 12'($random(seed));
        vaux_code_i = 12'($random(seed));
        pin_val_i = {1'b0, 15'($random(seed))};
        sample_valid_i = 1'b1;
        tick(1);
        sample_valid_i = 1'b0;
        tick(3);
    endtask

    // Results are settled by the falling edge
    always @(negedge mclk_i) begin
        if (rd_valid_o === 1'b1 || rd_err_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail_count++;
                $display("unexpected read word: expected none seen %h", rd_data_o);
            end else begin
                cmp_rd(exp_q.pop_front(), {rd_err_o, rd_data_o});
            end
        end
    end

    initial begin
        #100000;
        fail_count++;
        final_report();
    end

    initial begin
        {rst_n_i, uv_fault_i, ov_fault_i, oc_timeout_i, regulation_timer_active_warning_i, fet_bad_i, sample_valid_i} = 7'h00;
        {vin_code_i, vaux_code_i, iout_code_i, lim} = 48'h0;
        cml_err_i = 1'b0;
        pin_val_i = 16'h0000;
        repeat (5) @(posedge mclk_i);
        #1;
        rst_n_i = 1'b1;
        cmp_pin("alert1_oe", 1'b0, alert1_oe_o);
        cmp_pin("alert2_oe", 1'b0, alert2_oe_o);
        for (int i = 0; i < 8; i++) rd(RC[i], {1'b0, RV[i]});
        rd(8'h19, 17'h10000);
        cml_err_i = 1'b1;
        tick(1);
        cml_err_i = 1'b0;
        rd(CMD_STATUS_WORD, 17'h00008);
        for (int i = 0; i < 3; i++) begin
            host.wr(CMD_OPERATION, 16'h0000);
            host.wr(CMD_OPERATION, 16'h0080);
            tick(2);
            cmp_pin("hs_enable", 1'b1, hs_enable_o);
            rd(CMD_STATUS_WORD, 17'h00000);
            {oc_timeout_i, ov_fault_i, uv_fault_i} = 3'b001 << i;
            tick(2);
            {oc_timeout_i, ov_fault_i, uv_fault_i} = 3'b000;
            tick(2);
            cmp_pin("hs_enable", 1'b0, hs_enable_o);
            rd(CMD_MFR_STATUS, {15'h0000, 2'(i + 1)});
            rd(CMD_STATUS_WORD, {1'b0, 16'h0001 << i});
        end
        ov_fault_i = 1'b1;
        tick(2);
        host.wr(CMD_CLEAR_FAULTS, 16'h0000);
        rd(CMD_STATUS_WORD, 17'h00002);
        ov_fault_i = 1'b0;
        host.wr(CMD_CLEAR_FAULTS, 16'h0000);
        rd(CMD_STATUS_WORD, 17'h00000);
        host.wr(CMD_OPERATION, 16'h0000);
        host.wr(CMD_OPERATION, 16'h0080);
        fet_bad_i = 1'b1;
        tick(3);
        cmp_pin("alert1_oe", 1'b1, alert1_oe_o);
        cmp_pin("alert2_oe", 1'b0, alert2_oe_o);
        host.ara(1'b0);
        tick(2);
        cmp_pin("alert1_oe", 1'b0, alert1_oe_o);
        // CRC-8 of bytes 19 and 57 is 48
        cmp_byte("ara_pec", 8'h48, ara_pec_o);
        host.wr(CMD_ALERT2_CFG, 16'h0010);
        regulation_timer_active_warning_i = 1'b1;
        tick(3);
        cmp_pin("alert2_oe", 1'b1, alert2_oe_o);
        cmp_pin("alert1_oe", 1'b0, alert1_oe_o);
        host.ara(1'b1);
        tick(2);
        cmp_pin("alert2_oe", 1'b1, alert2_oe_o);
        host.wr(CMD_CLEAR_FAULTS, 16'h0000);
        tick(2);
        cmp_pin("alert2_oe", 1'b0, alert2_oe_o);
        rd(CMD_STATUS_WORD, 17'h01010);
        host.wr(CMD_ALERT2_CFG, 16'h2000);
        tick(2);
        cmp_pin("alert2_oe", 1'b1, alert2_oe_o);
        host.wr(CMD_ALERT2_CFG, 16'h0000);
        tick(2);
        lim = 12'h100 + 12'($random(seed) & 32'h7ff);
        host.wr(CMD_IOUT_OC_LIM, {4'h0, lim});
        host.wr(CMD_ALERT1_CFG, 16'h8020);
        rd(CMD_IOUT_OC_LIM, {5'h00, lim});
        sample(lim);
        cmp_pin("alert1_oe", 1'b0, alert1_oe_o);
        sample(lim + 12'h001);
        cmp_pin("alert1_oe", 1'b1, alert1_oe_o);
        rd(CMD_IOUT, {5'h00, iout_code_i});
        rd(CMD_VIN, {5'h00, vin_code_i});
        host.wr(CMD_CLEAR_FAULTS, 16'h0000);
        tick(2);
        cmp_pin("alert1_oe", 1'b0, alert1_oe_o);
        sample(lim + 12'h002);
        cmp_pin("alert1_oe", 1'b1, alert1_oe_o);
        host.wr(CMD_ALERT2_CFG, 16'h4020);
        tick(2);
        cmp_pin("alert2_oe", 1'b1, alert2_oe_o);
        sample(lim);
        cmp_pin("alert2_oe", 1'b0, alert2_oe_o);
        host.ara(1'b0);
        rd(CMD_STATUS_WORD, 17'h01030);
        host.wr(CMD_CLEAR_FAULTS, 16'h0000);
        tick(4);
        final_report();
    end
endmodule

`default_nettype wire
